/* hw/spfd_pkg.sv */
// Purpose: Shared constants and types of the single-precision float divider.
// Assumes: 36-bit ones-complement words, 8-bit characteristic, 27-bit mantissa.
// Notes: Octal figures of the characteristic arithmetic are given in hex.
//
// Behaviour
// [RULE_01] Load dividend and divisor into 36-bit registers
// [RULE_02] Quotient sign from signs; negatives complemented
// [RULE_03] Remainder sign follows dividend leftmost bit
// [RULE_04] Clear characteristic fields, clear quotient register
// [RULE_05] Zero divisor reports divide fault, aborts
// [RULE_06] Divide mantissas in 27 or 28 subtractions
// [RULE_07] First borrow selects 27, else 26 more
// [RULE_08] No borrow: keep difference, set quotient bit
// [RULE_09] Borrow: discard difference, keep quotient bit
// [RULE_10] Rotate both registers left, except after last
// [RULE_11] Low 27 bits hold quotient, remainder mantissas
// [RULE_12] Nine-bit adder subtracts divisor from dividend characteristic
// [RULE_13] Bias 200/201 quotient, minus 33/32 remainder
// [RULE_14] Nonzero quotient above 377 reports overflow
// [RULE_15] Nonzero quotient negative characteristic reports underflow
// [RULE_16] Pack quotient mantissa and characteristic fields
// [RULE_17] Complement quotient when operand signs differ
// [RULE_18] Zero mantissa: pack control picks +0 or pack
// [RULE_19] Zero mantissa with range error clears characteristic
// [RULE_20] Pack remainder; negative characteristic gives +0
// [RULE_21] Deliver quotient and remainder words together
// [RULE_22] Caller supplies normalized operands only
// [RULE_23] Operands held until done; done one cycle

package spfd_pkg;

	// ************************************************************
	// Word layout
	// ************************************************************
	localparam int WORD_W = 36;
	localparam int MANT_W = 27;
	localparam int CHAR_W = 9;
	localparam int SIGN_BIT = 35;
	localparam int CHAR_HI = 34;
	localparam int CHAR_LO = 27;
	localparam int MANT_HI = 26;

	// ************************************************************
	// Characteristic arithmetic (octal 200, 201, 33, 32, 377)
	// ************************************************************
	localparam logic [8:0] QBIAS_BORROW = 9'h080;
	localparam logic [8:0] QBIAS_NOBORROW = 9'h081;
	localparam logic [8:0] ROFF_BORROW = 9'h01b;
	localparam logic [8:0] ROFF_NOBORROW = 9'h01a;
	localparam logic [9:0] CHAR_MAX = 10'h0ff;

	// ************************************************************
	// Cycle counts after the first subtraction
	// ************************************************************
	localparam logic [4:0] MORE_NOBORROW = 5'h1a;
	localparam logic [4:0] MORE_BORROW = 5'h1b;

	// Reset values
	localparam logic [35:0] WORD_ZERO = 36'h000000000;

	typedef enum logic [2:0] {
		SPFD_IDLE,
		SPFD_CHECK,
		SPFD_DIVIDE,
		SPFD_PACK
	} spfd_state_t;

endpackage

/* hw/spfd_main_adder.sv */
// Purpose: Mantissa subtractor of the divider.
// Assumes: Both inputs are positive magnitudes.
// Notes: Borrow out stands for the end-around borrow of the subtraction.

`timescale 1ns/1ps
`default_nettype none

module spfd_main_adder #(
	parameter int W = 36
) (
	// Operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	// Result
	output logic [W-1:0] diff,
	output logic borrow
);

	// ************************************************************
	// Subtract
	// ************************************************************
	logic [W:0] full;

	// One extra bit catches the borrow; a equal to b gives no borrow
	assign full = {1'b0, a} - {1'b0, b};
	assign diff = full[W-1:0];
	assign borrow = full[W];

endmodule

`default_nettype wire

/* hw/spfd_char_adder.sv */
// Purpose: Characteristic adder of the divider.
// Assumes: Inputs are signed W-bit values.
// Notes: Result is one bit wider so that out-of-range sums stay visible.

`timescale 1ns/1ps
`default_nettype none

module spfd_char_adder #(
	parameter int W = 9
) (
	// Operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	input wire logic sub,
	// Result
	output logic [W:0] sum
);

	// ************************************************************
	// Add or subtract
	// ************************************************************
	logic [W:0] ax;
	logic [W:0] bx;

	// Sign extension keeps negative differences correct
	assign ax = {a[W-1], a};
	assign bx = {b[W-1], b};
	assign sum = sub ? (ax - bx) : (ax + bx);

endmodule

`default_nettype wire

/* hw/spfd_divider.sv */
// Purpose: Single-precision floating-point divide datapath.
// Assumes: Operands normalized and stable from start until done.
// Notes: Results and error flags appear together with a one-cycle done.

`timescale 1ns/1ps
`default_nettype none

module spfd_divider
	import spfd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Request from instruction control
	input wire logic start,
	input wire logic [35:0] dividend,
	input wire logic [35:0] divisor,
	input wire logic zero_mantissa_pack_control,
	// Answer to the control register file
	output logic busy,
	output logic done,
	output logic [35:0] quotient,
	output logic [35:0] remainder,
	output logic divide_fault,
	output logic char_overflow,
	output logic char_underflow
);

	// ************************************************************
	// State
	// ************************************************************
	spfd_state_t state;
	logic [35:0] rem;
	logic [35:0] dvs;
	logic [35:0] quo;
	logic [7:0] dvd_char;
	logic [7:0] dvs_char;
	logic q_neg;
	logic r_neg;
	logic zpc;
	logic [4:0] cnt;
	logic first_borrow;

	// ************************************************************
	// Unpack the incoming operands
	// ************************************************************
	logic [35:0] dvd_abs;
	logic [35:0] dvs_abs;
	logic [35:0] dvd_clr;
	logic [35:0] dvs_clr;
	logic accept;

	// Negative operands become positive by complement
	assign dvd_abs = dividend[SIGN_BIT] ? ~dividend : dividend; // [RULE_02]
	assign dvs_abs = divisor[SIGN_BIT] ? ~divisor : divisor; // [RULE_02]
	// Characteristic field cleared so only the mantissa is divided
	assign dvd_clr = {dvd_abs[SIGN_BIT], 8'h00, dvd_abs[MANT_HI:0]}; // [RULE_04]
	assign dvs_clr = {dvs_abs[SIGN_BIT], 8'h00, dvs_abs[MANT_HI:0]}; // [RULE_04]
	assign accept = (state == SPFD_IDLE) && start;

	// ************************************************************
	// Mantissa subtraction step
	// ************************************************************
	logic [35:0] add_diff;
	logic add_borrow;
	logic eff_first;
	logic [4:0] last_idx;
	logic is_last;
	logic [35:0] rem_step;
	logic [35:0] quo_step;
	logic [35:0] next_rem;
	logic [35:0] next_quo;
	logic dvs_zero;

	spfd_main_adder #(
		.W(WORD_W)
	) u_main_adder (
		.a(rem),
		.b(dvs),
		.diff(add_diff),
		.borrow(add_borrow)
	);

	// The first borrow fixes the length of the whole division
	assign eff_first = (cnt == 5'h00) ? add_borrow : first_borrow;
	assign last_idx = eff_first ? MORE_BORROW : MORE_NOBORROW; // [RULE_07]
	assign is_last = (cnt == last_idx); // [RULE_06]
	// Keep the difference only when no borrow came out
	assign rem_step = add_borrow ? rem : add_diff; // [RULE_08] [RULE_09]
	assign quo_step = add_borrow ? quo : {quo[35:1], 1'b1}; // [RULE_08] [RULE_09]
	// Circular rotation prepares the next step, skipped after the last
	assign next_rem = is_last ? rem_step : {rem_step[34:0], rem_step[35]}; // [RULE_10]
	assign next_quo = is_last ? quo_step : {quo_step[34:0], quo_step[35]}; // [RULE_10]
	assign dvs_zero = (dvs == WORD_ZERO); // [RULE_05]

	// ************************************************************
	// Characteristic arithmetic
	// ************************************************************
	logic [9:0] cdiff;
	logic [9:0] qsum;
	logic [9:0] rsum;

	// Difference without bias; it always fits nine signed bits
	spfd_char_adder #(
		.W(CHAR_W)
	) u_char_diff (
		.a({1'b0, dvd_char}),
		.b({1'b0, dvs_char}),
		.sub(1'b1),
		.sum(cdiff)
	); // [RULE_12]

	spfd_char_adder #(
		.W(CHAR_W)
	) u_char_quo (
		.a(cdiff[8:0]),
		.b(first_borrow ? QBIAS_BORROW : QBIAS_NOBORROW),
		.sub(1'b0),
		.sum(qsum)
	); // [RULE_13]

	spfd_char_adder #(
		.W(CHAR_W)
	) u_char_rem (
		.a({1'b0, dvd_char}),
		.b(first_borrow ? ROFF_BORROW : ROFF_NOBORROW),
		.sub(1'b1),
		.sum(rsum)
	); // [RULE_13]

	// ************************************************************
	// Range tests and packing
	// ************************************************************
	logic quo_nz;
	logic mant_zero;
	logic q_big;
	logic q_negc;
	logic rep_ovf;
	logic rep_unf;
	logic [7:0] q_fld;
	logic [35:0] q_pack;
	logic [35:0] q_final;
	logic [35:0] r_pack;
	logic [35:0] r_final;

	assign quo_nz = (quo != WORD_ZERO);
	assign mant_zero = (quo[MANT_HI:0] == 27'h0000000);
	assign q_big = !qsum[9] && (qsum > CHAR_MAX);
	assign q_negc = qsum[9];
	// Range errors are reported only for a nonzero quotient
	assign rep_ovf = quo_nz && !mant_zero && q_big; // [RULE_14]
	assign rep_unf = quo_nz && !mant_zero && q_negc; // [RULE_15]
	// Zero mantissa under a range error takes a cleared characteristic
	assign q_fld = (mant_zero && (q_big || q_negc)) ? 8'h00 : qsum[7:0]; // [RULE_19]
	assign q_pack = {1'b0, q_fld, quo[MANT_HI:0]}; // [RULE_16] [RULE_11]
	// Complement after packing so the sign covers every field
	assign q_final = (mant_zero && !zpc) ? WORD_ZERO : // [RULE_18]
		(q_neg ? ~q_pack : q_pack); // [RULE_17]
	// Negative remainder characteristic gives +0, left uncomplemented
	assign r_pack = rsum[9] ? WORD_ZERO : {1'b0, rsum[7:0], rem[MANT_HI:0]}; // [RULE_20] [RULE_11]
	assign r_final = (r_neg && !rsum[9]) ? ~r_pack : r_pack; // [RULE_20] [RULE_03]

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Operands are taken once at start; the caller keeps them stable anyway
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= SPFD_IDLE;
		end else begin
			case (state)
				SPFD_IDLE: begin
					if (start) begin
						state <= SPFD_CHECK;
					end
				end
				SPFD_CHECK: begin
					state <= dvs_zero ? SPFD_IDLE : SPFD_DIVIDE; // [RULE_05]
				end
				SPFD_DIVIDE: begin
					if (is_last) begin
						state <= SPFD_PACK; // [RULE_06]
					end
				end
				SPFD_PACK: begin
					state <= SPFD_IDLE;
				end
				default: begin
					state <= SPFD_IDLE;
				end
			endcase
		end
	end

	// Step counter and first-borrow memory
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 5'h00;
			first_borrow <= 1'b0;
		end else if (state == SPFD_CHECK) begin
			cnt <= 5'h00;
		end else if (state == SPFD_DIVIDE) begin
			cnt <= cnt + 5'h01;
			first_borrow <= eff_first; // [RULE_07]
		end
	end

	// ************************************************************
	// Datapath registers
	// ************************************************************
	// Load and unpack at start, then iterate during the division
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rem <= WORD_ZERO;
			dvs <= WORD_ZERO;
			quo <= WORD_ZERO;
		end else if (accept) begin
			rem <= dvd_clr; // [RULE_01]
			dvs <= dvs_clr; // [RULE_01]
			quo <= WORD_ZERO; // [RULE_04]
		end else if (state == SPFD_DIVIDE) begin
			rem <= next_rem;
			quo <= next_quo;
		end
	end

	// Signs, characteristics and pack control saved at start
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dvd_char <= 8'h00;
			dvs_char <= 8'h00;
			q_neg <= 1'b0;
			r_neg <= 1'b0;
			zpc <= 1'b0;
		end else if (accept) begin
			dvd_char <= dvd_abs[CHAR_HI:CHAR_LO]; // [RULE_04]
			dvs_char <= dvs_abs[CHAR_HI:CHAR_LO]; // [RULE_04]
			q_neg <= dividend[SIGN_BIT] ^ divisor[SIGN_BIT]; // [RULE_02]
			r_neg <= dividend[SIGN_BIT]; // [RULE_03]
			zpc <= zero_mantissa_pack_control;
		end
	end

	// ************************************************************
	// Answer registers
	// ************************************************************
	// Flags are pulses beside done; results hold until the next good answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done <= 1'b0;
			divide_fault <= 1'b0;
			char_overflow <= 1'b0;
			char_underflow <= 1'b0;
		end else begin
			done <= (state == SPFD_PACK) || ((state == SPFD_CHECK) && dvs_zero); // [RULE_23]
			divide_fault <= (state == SPFD_CHECK) && dvs_zero; // [RULE_05]
			char_overflow <= (state == SPFD_PACK) && rep_ovf; // [RULE_14]
			char_underflow <= (state == SPFD_PACK) && rep_unf; // [RULE_15]
		end
	end

	// Both words land together for the two consecutive control registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			quotient <= WORD_ZERO;
			remainder <= WORD_ZERO;
		end else if ((state == SPFD_PACK) && !rep_ovf && !rep_unf) begin
			quotient <= q_final; // [RULE_21]
			remainder <= r_final; // [RULE_21]
		end
	end

	// Busy covers the whole operation so a new start is never lost silently
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
		end else begin
			busy <= accept || ((state != SPFD_IDLE) && !((state == SPFD_CHECK) && dvs_zero)
				&& (state != SPFD_PACK));
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	sequence s_accept;
		(state == SPFD_IDLE) && start;
	endsequence

	sequence s_answer;
		##[2:32] done;
	endsequence

	property p_done_pulse;
		@(posedge clk) disable iff (!arst_n)
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle"); // [RULE_23]

	property p_latency;
		@(posedge clk) disable iff (!arst_n)
		s_accept |-> s_answer;
	endproperty
	a_latency: assert property (p_latency) else $error("no answer after start"); // [RULE_06]

	property p_fault;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_CHECK) && dvs_zero |=> done && divide_fault && (state == SPFD_IDLE);
	endproperty
	a_fault: assert property (p_fault) else $error("zero divisor not faulted"); // [RULE_05]

	// Lengths are counted from the state itself, not from the step counter
	sequence s_short_run;
		##26 (state == SPFD_DIVIDE) ##1 (state == SPFD_PACK);
	endsequence

	sequence s_long_run;
		##27 (state == SPFD_DIVIDE) ##1 (state == SPFD_PACK);
	endsequence

	property p_steps;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_DIVIDE) && (cnt == 5'h00) && !add_borrow |-> s_short_run;
	endproperty
	a_steps: assert property (p_steps) else $error("wrong step count without borrow"); // [RULE_07]

	property p_steps_long;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_DIVIDE) && (cnt == 5'h00) && add_borrow |-> s_long_run;
	endproperty
	a_steps_long: assert property (p_steps_long) else $error("wrong step count with borrow"); // [RULE_07]

	property p_set_bit;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_DIVIDE) && !add_borrow && !is_last |=> quo[1] && (rem[0] == $past(add_diff[35]));
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("quotient bit not set"); // [RULE_08]

	property p_discard;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_DIVIDE) && add_borrow && is_last |=> (rem == $past(rem)) && (quo == $past(quo));
	endproperty
	a_discard: assert property (p_discard) else $error("borrowed step changed registers"); // [RULE_09]

	property p_ovf;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_PACK) && quo_nz && !mant_zero && q_big |=> done && char_overflow && !char_underflow;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow not reported"); // [RULE_14]

	property p_unf;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_PACK) && quo_nz && !mant_zero && q_negc |=> done && char_underflow;
	endproperty
	a_unf: assert property (p_unf) else $error("underflow not reported"); // [RULE_15]

	property p_qsign;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_PACK) && !rep_ovf && !rep_unf && !mant_zero |=> quotient[35] == $past(q_neg);
	endproperty
	a_qsign: assert property (p_qsign) else $error("quotient sign wrong"); // [RULE_17]

	property p_zero_pack;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_PACK) && mant_zero && !zpc |=> done && (quotient == 36'h000000000);
	endproperty
	a_zero_pack: assert property (p_zero_pack) else $error("zero quotient not +0"); // [RULE_18]

	property p_rsign;
		@(posedge clk) disable iff (!arst_n)
		(state == SPFD_PACK) && !rep_ovf && !rep_unf && !rsum[9] |=> remainder[35] == $past(r_neg);
	endproperty
	a_rsign: assert property (p_rsign) else $error("remainder sign wrong"); // [RULE_03]

endmodule

`default_nettype wire

/* dv/spfd_ctl_model.sv */
// Purpose: Instruction control and control register file facing the divider.
// Assumes: One request at a time; operands held from start until done.
// Notes: Released operand lines show inverted data so stale values never pass.

`timescale 1ns/1ps
`default_nettype none

module spfd_ctl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Request toward the divider
	output logic start,
	output logic [35:0] dividend,
	output logic [35:0] divisor,
	output logic zero_mantissa_pack_control,
	// Answer from the divider
	input wire logic busy,
	input wire logic done,
	input wire logic [35:0] quotient,
	input wire logic [35:0] remainder,
	input wire logic divide_fault,
	input wire logic char_overflow,
	input wire logic char_underflow
);
	logic [35:0] ctl_reg [0:1];

	// Idle request lines at time zero
	initial begin
		start = 1'b0;
		dividend = 36'h000000000;
		divisor = 36'h000000000;
		zero_mantissa_pack_control = 1'b0;
	end

	// Good answers land in two consecutive control registers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl_reg[0] <= 36'h000000000;
			ctl_reg[1] <= 36'h000000000;
		end else if (done && !(divide_fault || char_overflow || char_underflow)) begin
			ctl_reg[0] <= quotient;
			ctl_reg[1] <= remainder;
		end
	end

	// ************************************************************
	// One divide request; pre means start is already up for this edge
	// ************************************************************
	task automatic divide(input logic [35:0] a, input logic [35:0] b, input logic z,
		input bit pre, input int poke, input logic [35:0] pa, input logic [35:0] pb,
		output int n, output logic [2:0] fl, output logic [35:0] q, output logic [35:0] r);
		if (!pre) begin
			@(posedge clk);
			start <= 1'b1;
			dividend <= a;
			divisor <= b;
			zero_mantissa_pack_control <= z;
		end
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		// Operands stay put until done; a poke raises start once more
		while (n < 40) begin
			@(negedge clk);
			n++;
			if (done === 1'b1) begin
				break;
			end
			if (n == poke - 1) begin
				@(posedge clk);
				start <= 1'b1;
				dividend <= pa;
				divisor <= pb;
			end else if (n == poke) begin
				@(posedge clk);
				start <= 1'b0;
			end
		end
		fl = {divide_fault, char_overflow, char_underflow};
		q = quotient;
		r = remainder;
		// Release the operand lines unless the next request follows at once
		if (n != poke) begin
			@(posedge clk);
			dividend <= ~dividend;
			divisor <= ~divisor;
		end
	endtask
endmodule

`default_nettype wire

/* dv/tb.sv */
// Purpose: Self-checking bench of the single-precision float divider.
// Assumes: Normalized operands; expectations from a bit-serial reference.
// Notes: Range errors and faults leave the previous results on the outputs.

`timescale 1ns/1ps
`default_nettype none

module tb;
	import spfd_pkg::*;
	logic clk, arst_n, start, zmpc, busy, done, dfault, ovf, unf;
	logic [35:0] dvd, dvs, quo, rem, last_q, last_r;
	int fail_count = 0;
	int checks = 0;

	spfd_divider DUT (.clk(clk), .arst_n(arst_n), .start(start), .dividend(dvd), .divisor(dvs),
		.zero_mantissa_pack_control(zmpc), .busy(busy), .done(done), .quotient(quo),
		.remainder(rem), .divide_fault(dfault), .char_overflow(ovf), .char_underflow(unf));
	spfd_ctl_model ctl (.clk(clk), .arst_n(arst_n), .start(start), .dividend(dvd), .divisor(dvs),
		.zero_mantissa_pack_control(zmpc), .busy(busy), .done(done), .quotient(quo),
		.remainder(rem), .divide_fault(dfault), .char_overflow(ovf), .char_underflow(unf));

	// ************************************************************
	// Compare helpers and verdict
	// ************************************************************
	task automatic chk_word(input string nm, input logic [35:0] e, input logic [35:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_bit(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_count(input string nm, input int e, input int g);
		checks++;
		if (g != e) begin
			fail_count++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("Counts: checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Builds a normalized word of given sign, characteristic and mantissa
	function automatic logic [35:0] mk(input logic s, input logic [7:0] c, input logic [26:0] m);
		return {1'b0, c, m} ^ {36{s}};
	endfunction

	// Bit-serial restoring reference; n is cycles from taking edge to done
	function automatic void ref_div(input logic [35:0] a, input logic [35:0] b, input logic z,
		output logic [35:0] q, output logic [35:0] r, output logic [2:0] fl, output int n);
		logic [35:0] x, y, qq;
		logic bw;
		logic signed [9:0] qc, rc;
		int k;
		x = a[35] ? ~a : a;
		y = b[35] ? ~b : b;
		qc = $signed({2'b00, x[34:27]}) - $signed({2'b00, y[34:27]});
		rc = $signed({2'b00, x[34:27]});
		x[34:27] = 8'h00;
		y[34:27] = 8'h00;
		qq = 36'h000000000;
		q = 36'h000000000;
		r = 36'h000000000;
		fl = 3'h0;
		n = 2;
		if (y == 36'h000000000) begin
			fl = 3'h4;
			return;
		end
		bw = x < y;
		k = bw ? 28 : 27;
		n = k + 3;
		for (int i = 0; i < k; i++) begin
			if (x >= y) begin
				x = x - y;
				qq[0] = 1'b1;
			end
			if (i < k - 1) begin
				x = {x[34:0], x[35]};
				qq = {qq[34:0], qq[35]};
			end
		end
		qc = qc + $signed({1'b0, bw ? QBIAS_BORROW : QBIAS_NOBORROW});
		rc = rc - $signed({1'b0, bw ? ROFF_BORROW : ROFF_NOBORROW});
		if (qq[26:0] != 27'h0 && qc > 255) fl = 3'h2;
		if (qq[26:0] != 27'h0 && qc < 0) fl = 3'h1;
		if (fl != 3'h0) return;
		if (qq[26:0] != 27'h0 || z) begin
			q = {1'b0, (qc < 0 || qc > 255) ? 8'h00 : qc[7:0], qq[26:0]} ^ {36{a[35] ^ b[35]}};
		end
		if (rc >= 0) r = {1'b0, rc[7:0], x[26:0]} ^ {36{a[35]}};
	endfunction

	// One request judged in full; poke raises start again at that cycle
	task automatic run_case(input string nm, input logic [35:0] a, input logic [35:0] b,
		input logic z, input bit pre, input int poke, input logic [35:0] pa, input logic [35:0] pb);
		int n, en;
		logic [2:0] fl, efl;
		logic [35:0] q, r, eq, er;
		ref_div(a, b, z, eq, er, efl, en);
		if (efl != 3'h0) begin
			eq = last_q;
			er = last_r;
		end
		ctl.divide(a, b, z, pre, poke, pa, pb, n, fl, q, r);
		chk_count({nm, "_cycles"}, en, n);
		chk_bit({nm, "_fault"}, efl[2], fl[2]);
		chk_bit({nm, "_ovf"}, efl[1], fl[1]);
		chk_bit({nm, "_unf"}, efl[0], fl[0]);
		chk_word({nm, "_quo"}, eq, q);
		chk_word({nm, "_rem"}, er, r);
		last_q = eq;
		last_r = er;
		if (poke != en) begin
			@(negedge clk);
			chk_bit({nm, "_done_low"}, 1'b0, done);
			chk_word({nm, "_creg"}, last_q, ctl.ctl_reg[0]);
			chk_word({nm, "_creg_rem"}, last_r, ctl.ctl_reg[1]);
		end
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_plain;
		run_case("noborrow", mk(0, 8'h81, 27'h6000000), mk(0, 8'h81, 27'h4000000), 1'b0, 0, 0, 0, 0);
		run_case("borrow", mk(0, 8'h81, 27'h4000000), mk(0, 8'h80, 27'h6000000), 1'b0, 0, 0, 0, 0);
		$display("t_plain done");
	endtask
	task automatic t_signs;
		for (int s = 0; s < 4; s++) begin
			run_case("signs", mk(s[1], 8'h85, 27'h5555555), mk(s[0], 8'h82, 27'h7000001), 1'b1, 0, 0, 0, 0);
		end
		$display("t_signs done");
	endtask
	task automatic t_fault;
		run_case("fault_pz", mk(0, 8'h81, 27'h4000000), 36'h000000000, 1'b0, 0, 0, 0, 0);
		run_case("fault_mz", mk(1, 8'h81, 27'h4000000), 36'hfffffffff, 1'b0, 0, 0, 0, 0);
		run_case("fault_cz", mk(0, 8'h81, 27'h4000000), mk(1, 8'h90, 27'h0), 1'b1, 0, 0, 0, 0);
		$display("t_fault done");
	endtask
	task automatic t_range;
		run_case("ovf", mk(1, 8'hff, 27'h6000000), mk(0, 8'h01, 27'h4000000), 1'b0, 0, 0, 0, 0);
		run_case("unf", mk(0, 8'h01, 27'h4000000), mk(0, 8'hff, 27'h6000000), 1'b1, 0, 0, 0, 0);
		$display("t_range done");
	endtask
	task automatic t_zero;
		run_case("zero_d0", 36'h000000000, mk(1, 8'h81, 27'h4000000), 1'b0, 0, 0, 0, 0);
		run_case("zero_d1", 36'h000000000, mk(1, 8'h81, 27'h4000000), 1'b1, 0, 0, 0, 0);
		$display("t_zero done");
	endtask
	task automatic t_order;
		logic [35:0] a, b;
		a = mk(1, 8'h88, 27'h7654321);
		b = mk(0, 8'h84, 27'h4abcdef);
		// Busy start is ignored, then a start on the done cycle is taken
		run_case("poke", a, b, 1'b0, 0, 10, a, b);
		run_case("b2b_a", mk(0, 8'h81, 27'h6000000), mk(0, 8'h81, 27'h4000000), 1'b0, 0, 30, a, b);
		run_case("b2b_b", a, b, 1'b0, 1, 0, 0, 0);
		$display("t_order done");
	endtask

	// ************************************************************
	// Clock, reset, sequence and watchdog
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		arst_n = 1'b0;
		last_q = 36'h000000000;
		last_r = 36'h000000000;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk_bit("reset_busy", 1'b0, busy);
		chk_word("reset_quo", 36'h000000000, quo);
		t_plain();
		t_signs();
		t_fault();
		t_range();
		t_zero();
		t_order();
		tally_and_finish();
	end
	// 16 requests of at most 35 cycles each
	initial begin
		repeat (2000) @(posedge clk);
		fail_count++;
		$display("ERROR watchdog expected finish seen hang");
		tally_and_finish();
	end
endmodule

`default_nettype wire
